// *** verilog/program_flow_sequencer.sv ***
// control-flow sequencer: conditionals, call stack and auto-start
// What this block does
// - true if condition: execute the commands right after the if
// - false if: discard commands until matching else or end-if
// - with else: false runs after else, true runs only if-to-else part
// - conditional blocks nest up to 255 levels
// - a condition is satisfied when its value is nonzero
// - a jump or call with no condition is always taken
// - subroutine entered by a call naming a target with optional condition
// - subroutine calls nest up to 8 deep
// - after a subroutine, resume at the line after the call unless stack altered
// - calls, interrupts and monitoring routine entries push the stack by 1
// - an end inside a subroutine pops the stack and returns
// - pop-one removes one level, execution continues at the next line
// - clear-all returns the stack to empty, dropping all returns
// - at reset, start the stored program at the auto-start label
// - program lines are numbered from zero
`timescale 1ns/1ps
module program_flow_sequencer
    import flow_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              cmd_valid_i,
    input  wire op_t               cmd_op_i,
    input  wire logic              cmd_has_cond_i,
    input  wire logic [COND_W-1:0] cmd_cond_i,
    input  wire logic [ADDR_W-1:0] cmd_target_i,
    input  wire logic              auto_present_i,
    input  wire logic [ADDR_W-1:0] auto_line_i,
    output logic                   pc_load_o,
    output logic [ADDR_W-1:0]      pc_o,
    output logic                   running_o,
    output logic                   skipping_o,
    output logic [IF_DEPTH_W-1:0]  if_depth_o,
    output logic [SP_W-1:0]        stack_depth_o,
    output logic                   fault_o
);
    state_t                  state_reg, state_next;
    logic [ADDR_W-1:0]       pc_reg, pc_next;
    logic                    load_reg, load_next;
    logic                    run_reg, run_next;
    logic [IF_DEPTH_W-1:0]   ifd_reg, ifd_next;
    logic [IF_DEPTH_W-1:0]   skd_reg, skd_next;
    logic [SP_W-1:0]         sp_reg, sp_next;
    logic                    fault_reg, fault_next;
    logic [ADDR_W-1:0]       stk_reg [STACK_DEPTH];
    logic [ADDR_W-1:0]       stk_next [STACK_DEPTH];
    logic                    skip_reg, skip_next;

    // every check below shares this clock and reset
    default clocking chk_clk @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    function automatic logic cond_true(input logic has_cond,
                                       input logic [COND_W-1:0] value);
        cond_true = !has_cond || (value != '0);
    endfunction : cond_true

    function automatic logic [ADDR_W-1:0] inc_line(input logic [ADDR_W-1:0] l);
        inc_line = ADDR_W'(l + 1'b1);
    endfunction : inc_line

    logic          exec;
    logic          taken;
    assign exec  = cmd_valid_i && (state_reg == ST_RUN);
    assign taken = cond_true(cmd_has_cond_i, cmd_cond_i);

    always_comb
    begin
        state_next = state_reg;
        pc_next    = pc_reg;
        load_next  = 1'b0;
        run_next   = run_reg;
        ifd_next   = ifd_reg;
        skd_next   = skd_reg;
        sp_next    = sp_reg;
        fault_next = fault_reg;
        stk_next   = stk_reg;
        case (state_reg)
            ST_BOOT:
            begin
                // boot strap sampled after reset release, not under it
                pc_next    = auto_present_i ? auto_line_i
                                            : FIRST_LINE;
                load_next  = auto_present_i;
                run_next   = auto_present_i;
                state_next = ST_RUN;
            end
            ST_RUN:
            begin
                if (cmd_valid_i)
                begin
                    pc_next = inc_line(pc_reg);
                    case (cmd_op_i)
                        OP_IF:
                        begin
                            if (ifd_reg == IF_DEPTH_MAX)
                                fault_next = 1'b1;
                            else
                                ifd_next = ifd_reg + 1'b1;
                            if (!taken)
                            begin
                                skd_next   = SKIP_OUTER;
                                state_next = ST_SKIP_ELSE;
                            end
                        end
                        OP_ELSE:
                        begin
                            // true branch done: skip the else part
                            skd_next   = SKIP_OUTER;
                            state_next = ST_SKIP_ENDIF;
                        end
                        OP_ENDIF:
                            if (ifd_reg != SKIP_NONE)
                                ifd_next = ifd_reg - 1'b1;
                        OP_JUMP:
                            if (taken)
                            begin
                                pc_next   = cmd_target_i;
                                load_next = 1'b1;
                            end
                        OP_CALL, OP_EVENT:
                            if (taken || cmd_op_i == OP_EVENT)
                            begin
                                if (sp_reg == SP_FULL)
                                    fault_next = 1'b1;
                                else
                                begin
                                    stk_next[sp_reg[2:0]] = inc_line(pc_reg);
                                    sp_next   = sp_reg + 1'b1;
                                    pc_next   = cmd_target_i;
                                    load_next = 1'b1;
                                end
                            end
                        OP_END:
                            if (sp_reg != SP_EMPTY)
                            begin
                                sp_next   = sp_reg - 1'b1;
                                pc_next   = stk_reg[3'(sp_reg - 1'b1)];
                                load_next = 1'b1;
                            end
                            else
                                run_next = 1'b0;
                        OP_POP_ONE:
                            if (sp_reg != SP_EMPTY)
                                sp_next = sp_reg - 1'b1;
                        OP_CLEAR_ALL:
                            sp_next = SP_EMPTY;
                        default: ;
                    endcase
                end
            end
            ST_SKIP_ELSE, ST_SKIP_ENDIF:
            begin
                if (cmd_valid_i)
                begin
                    pc_next = inc_line(pc_reg);
                    case (cmd_op_i)
                        OP_IF:
                            skd_next = skd_reg + 1'b1;
                        OP_ELSE:
                            if (skd_reg == SKIP_OUTER &&
                                state_reg == ST_SKIP_ELSE)
                            begin
                                skd_next   = SKIP_NONE;
                                state_next = ST_RUN;
                            end
                        OP_ENDIF:
                            if (skd_reg == SKIP_OUTER)
                            begin
                                skd_next   = SKIP_NONE;
                                ifd_next   = ifd_reg - 1'b1;
                                state_next = ST_RUN;
                            end
                            else
                                skd_next = skd_reg - 1'b1;
                        default: ;
                    endcase
                end
            end
            default: state_next = ST_BOOT;
        endcase
        // registered so the skip flag leaves straight from a flip-flop
        skip_next = (state_next == ST_SKIP_ELSE) ||
                    (state_next == ST_SKIP_ENDIF);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= ST_BOOT;
            pc_reg    <= FIRST_LINE;
            load_reg  <= 1'b0;
            run_reg   <= 1'b0;
            ifd_reg   <= SKIP_NONE;
            skd_reg   <= SKIP_NONE;
            sp_reg    <= SP_EMPTY;
            fault_reg <= 1'b0;
            skip_reg  <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stk_reg[i] <= FIRST_LINE;
        end
        else
        begin
            state_reg <= state_next;
            pc_reg    <= pc_next;
            load_reg  <= load_next;
            run_reg   <= run_next;
            ifd_reg   <= ifd_next;
            skd_reg   <= skd_next;
            sp_reg    <= sp_next;
            fault_reg <= fault_next;
            skip_reg  <= skip_next;
            stk_reg   <= stk_next;
        end
    end

    assign pc_load_o     = load_reg;
    assign pc_o          = pc_reg;
    assign running_o     = run_reg;
    assign skipping_o    = skip_reg;
    assign if_depth_o    = ifd_reg;
    assign stack_depth_o = sp_reg;
    assign fault_o       = fault_reg;

    sequence s_call_taken;
        exec && (cmd_op_i == OP_CALL) && taken && (sp_reg != SP_FULL);
    endsequence

    sequence s_end_taken;
        exec && (cmd_op_i == OP_END) && (sp_reg != SP_EMPTY);
    endsequence

    a_true_if_runs: assert property (
        exec && cmd_op_i == OP_IF && taken |=> !skipping_o)
        else $error("true if did not continue");
    a_false_if_skips: assert property (
        exec && cmd_op_i == OP_IF && !taken |=> skipping_o)
        else $error("false if did not skip");
    a_else_skips: assert property (
        exec && cmd_op_i == OP_ELSE |=> state_reg == ST_SKIP_ENDIF)
        else $error("else after true branch not skipped");
    a_if_depth_cap: assert property (
        exec && cmd_op_i == OP_IF && ifd_reg == IF_DEPTH_MAX
        |=> fault_o && $stable(if_depth_o))
        else $error("if depth passed 255");
    a_nonzero_cond: assert property (
        exec && cmd_op_i == OP_JUMP && cmd_has_cond_i && cmd_cond_i == '0
        |=> !pc_load_o)
        else $error("zero condition took jump");
    a_call_pushes: assert property (
        s_call_taken |=> pc_load_o && stack_depth_o == $past(sp_reg) + 1'b1)
        else $error("call did not push");
    a_stack_cap: assert property (
        stack_depth_o <= SP_FULL)
        else $error("stack deeper than 8");
    a_return_line: assert property (
        s_call_taken ##1 s_end_taken |=> pc_o == $past(pc_o, 2) + 1'b1)
        else $error("return to wrong line");
    a_pop_one: assert property (
        exec && cmd_op_i == OP_POP_ONE && sp_reg != SP_EMPTY
        |=> !pc_load_o && stack_depth_o == $past(sp_reg) - 1'b1)
        else $error("pop one wrong");
    a_clear_all: assert property (
        exec && cmd_op_i == OP_CLEAR_ALL |=> stack_depth_o == SP_EMPTY)
        else $error("stack not cleared");
    a_auto_start: assert property (
        state_reg == ST_BOOT && auto_present_i
        |=> pc_load_o && running_o && pc_o == $past(auto_line_i))
        else $error("auto start not launched");
    a_plain_boot: assert property (
        state_reg == ST_BOOT && !auto_present_i
        |=> !pc_load_o && !running_o && pc_o == FIRST_LINE)
        else $error("boot without auto start not idle");
endmodule : program_flow_sequencer

// *** common/flow_pkg.sv ***
// constants and types for the program flow sequencer
package flow_pkg;
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned COND_W      = 32;
    localparam int unsigned IF_DEPTH_W  = 8;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned SP_W        = 4;
    localparam logic [IF_DEPTH_W-1:0] IF_DEPTH_MAX = 8'hff;
    localparam logic [SP_W-1:0]       SP_EMPTY     = 4'h0;
    localparam logic [SP_W-1:0]       SP_FULL      = 4'h8;
    localparam logic [ADDR_W-1:0]     FIRST_LINE   = 12'h000;
    localparam logic [IF_DEPTH_W-1:0] SKIP_NONE    = 8'h00;
    localparam logic [IF_DEPTH_W-1:0] SKIP_OUTER   = 8'h01;

    typedef enum logic [3:0] {
        OP_NOP,
        OP_IF,
        OP_ELSE,
        OP_ENDIF,
        OP_JUMP,
        OP_CALL,
        OP_END,
        OP_POP_ONE,
        OP_CLEAR_ALL,
        OP_EVENT
    } op_t;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_RUN,
        ST_SKIP_ELSE,
        ST_SKIP_ENDIF
    } state_t;
endpackage : flow_pkg

// *** tb/program_feeder.sv ***
// stand-in for the stored program: one command at a time
`timescale 1ns/1ps
module program_feeder
    import flow_pkg::*;
(
    input  wire logic         clk_i,
    output logic              cmd_valid_o,
    output op_t               cmd_op_o,
    output logic              cmd_has_cond_o,
    output logic [COND_W-1:0] cmd_cond_o,
    output logic [ADDR_W-1:0] cmd_target_o
);
    // set by the bench to force commands on consecutive cycles
    logic back_to_back = 1'b0;

    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_op_o = OP_NOP;
        cmd_has_cond_o = 1'b0;
        cmd_cond_o = '0;
        cmd_target_o = '0;
    end

    task automatic idle;
        cmd_valid_o = 1'b0;
    endtask : idle

    // entered on a falling edge; valid may still hold the last command
    task automatic issue(input op_t op, input logic hc,
                         input logic [COND_W-1:0] c,
                         input logic [ADDR_W-1:0] t);
        if (!back_to_back && ($urandom % 2) != 0)
        begin
            // random stall mimics a slow fetch
            cmd_valid_o = 1'b0;
            // idle lines carry junk so a stale value cannot pass
            cmd_cond_o = ~cmd_cond_o;
            cmd_target_o = ~cmd_target_o;
            @(negedge clk_i);
        end
        cmd_valid_o = 1'b1;
        cmd_op_o = op;
        cmd_has_cond_o = hc;
        cmd_cond_o = c;
        cmd_target_o = t;
        @(negedge clk_i);
    endtask : issue
endmodule : program_feeder

// *** tb/program_flow_sequencer_tb.sv ***
// self-checking bench for the program flow sequencer
`timescale 1ns/1ps
module program_flow_sequencer_tb
    import flow_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic              valid;
    op_t               op;
    logic              has_cond;
    logic [COND_W-1:0] cond;
    logic [ADDR_W-1:0] target;
    logic              auto_present = 1'b0;
    logic [ADDR_W-1:0] auto_line = '0;
    logic              pc_load;
    logic [ADDR_W-1:0] pc;
    logic              running;
    logic              skipping;
    logic [7:0]        if_depth;
    logic [SP_W-1:0]   stack;
    logic              fault;
    logic [ADDR_W-1:0] exp_pc;
    logic [ADDR_W-1:0] tg;
    logic [ADDR_W-1:0] rets[$];
    int                n_errors = 0;
    int                n_tests = 0;
    int                cycles = 0;

    always #4 clk_i = ~clk_i;

    program_feeder prog (.clk_i(clk_i), .cmd_valid_o(valid),
        .cmd_op_o(op), .cmd_has_cond_o(has_cond),
        .cmd_cond_o(cond), .cmd_target_o(target));

    program_flow_sequencer uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .cmd_valid_i(valid), .cmd_op_i(op), .cmd_has_cond_i(has_cond),
        .cmd_cond_i(cond), .cmd_target_i(target),
        .auto_present_i(auto_present), .auto_line_i(auto_line),
        .pc_load_o(pc_load), .pc_o(pc), .running_o(running),
        .skipping_o(skipping), .if_depth_o(if_depth),
        .stack_depth_o(stack), .fault_o(fault));

    task automatic complete_run;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [11:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // jmp says whether the command should redirect to t
    task automatic run(input op_t o, input logic hc,
                       input logic [COND_W-1:0] c,
                       input logic [ADDR_W-1:0] t, input logic jmp);
        logic [ADDR_W-1:0] nxt;
        nxt = jmp ? t : exp_pc + 12'h001;
        prog.issue(o, hc, c, t);
        exp_pc = nxt;
        chk("pc", exp_pc, pc);
        chk("pc_load", jmp, pc_load);
    endtask : run

    task automatic do_reset(input logic ap, input logic [ADDR_W-1:0] al);
        rst_b_i = 1'b0;
        auto_present = ap;
        auto_line = al;
        @(negedge clk_i);
        // the last command stays valid after a run; drop it before boot
        prog.idle();
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        @(negedge clk_i);
        exp_pc = ap ? al : FIRST_LINE;
        chk("boot_pc", exp_pc, pc);
        chk("boot_run", ap, running);
    endtask : do_reset

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            complete_run();
        end
    end

    initial
    begin
        void'($urandom(32'h8e63));
        do_reset(1'b1, 12'($urandom));
        run(OP_IF, 1'b1, 32'($urandom | 1), '0, 1'b0);
        chk("skip", 1'b0, skipping);
        chk("ifd", 8'h01, if_depth);
        run(OP_ELSE, 1'b0, '0, '0, 1'b0);
        chk("skip", 1'b1, skipping);
        run(OP_ENDIF, 1'b0, '0, '0, 1'b0);
        chk("skip", 1'b0, skipping);
        run(OP_IF, 1'b1, '0, '0, 1'b0);
        chk("skip", 1'b1, skipping);
        run(OP_CALL, 1'b0, '0, 12'h123, 1'b0);
        chk("stack", SP_EMPTY, stack);
        run(OP_IF, 1'b1, 32'h8000_0000, '0, 1'b0);
        run(OP_ELSE, 1'b0, '0, '0, 1'b0);
        chk("skip", 1'b1, skipping);
        run(OP_ENDIF, 1'b0, '0, '0, 1'b0);
        chk("skip", 1'b1, skipping);
        run(OP_ELSE, 1'b0, '0, '0, 1'b0);
        chk("skip", 1'b0, skipping);
        run(OP_ENDIF, 1'b0, '0, '0, 1'b0);
        chk("ifd", SKIP_NONE, if_depth);
        run(OP_CALL, 1'b1, '0, 12'h3c0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            tg = 12'($urandom);
            rets.push_back(exp_pc + 12'h001);
            run(i[0] ? OP_EVENT : OP_CALL, 1'b1, 32'($urandom | 1),
                tg, 1'b1);
            chk("stack", 12'(i + 1), stack);
        end
        run(OP_CALL, 1'b0, '0, 12'h0f0, 1'b0);
        chk("fault", 1'b1, fault);
        while (rets.size() > 0)
            run(OP_END, 1'b0, '0, rets.pop_back(), 1'b1);
        chk("stack", SP_EMPTY, stack);
        // jumps kept outside conditional blocks so no end-if is bypassed
        run(OP_JUMP, 1'b1, '0, 12'h0a5, 1'b0);
        run(OP_JUMP, 1'b1, 32'($urandom | 1), 12'h0a5, 1'b1);
        run(OP_JUMP, 1'b0, '0, 12'($urandom), 1'b1);
        chk("ifd", SKIP_NONE, if_depth);
        chk("stack", SP_EMPTY, stack);
        // call then end on consecutive cycles
        prog.back_to_back = 1'b1;
        tg = exp_pc + 12'h001;
        run(OP_CALL, 1'b1, 32'h0000_0100, 12'h111, 1'b1);
        run(OP_END, 1'b0, '0, tg, 1'b1);
        prog.back_to_back = 1'b0;
        do_reset(1'b1, 12'h7ff);
        run(OP_CALL, 1'b0, '0, 12'h200, 1'b1);
        run(OP_EVENT, 1'b0, '0, 12'h300, 1'b1);
        run(OP_POP_ONE, 1'b0, '0, '0, 1'b0);
        chk("stack", 12'h001, stack);
        run(OP_CALL, 1'b0, '0, 12'h010, 1'b1);
        run(OP_CLEAR_ALL, 1'b0, '0, '0, 1'b0);
        chk("stack", SP_EMPTY, stack);
        prog.issue(OP_END, 1'b0, '0, '0);
        chk("run", 1'b0, running);
        do_reset(1'b1, 12'h040);
        for (int i = 0; i < 255; i++)
            run(OP_IF, 1'b0, '0, '0, 1'b0);
        chk("ifd", IF_DEPTH_MAX, if_depth);
        chk("fault", 1'b0, fault);
        run(OP_IF, 1'b0, '0, '0, 1'b0);
        chk("fault", 1'b1, fault);
        chk("ifd", IF_DEPTH_MAX, if_depth);
        do_reset(1'b0, 12'h5a5);
        complete_run();
    end
endmodule : program_flow_sequencer_tb
